// [core/evreg_pkg.sv]
/*
  Shared constants and carrier types for the converter event flag
  register bank and its indirect configuration access path.
  Assumes a single 250 MHz clock and a plain strobe register port.
*/
package evreg_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_EVENT_FLAGS = 8'h54;
  localparam logic [7:0] OFF_EVENT_ENABLES = 8'h50;
  localparam logic [7:0] OFF_BASE_OFFSET = 8'h60;
  localparam logic [7:0] OFF_IND_ADDRESS = 8'h64;
  localparam logic [7:0] OFF_IND_WRITE = 8'h68;
  localparam logic [7:0] OFF_IND_READ = 8'h6C;
  localparam logic [7:0] OFF_IND_STATUS = 8'h70;

  // Event flag layout
  localparam int FLAG_W = 11;
  localparam int BIT_FIFO_OVERFLOW = 10;
  localparam int BIT_FIFO_UNDERFLOW = 9;
  localparam int BIT_FIFO_LEVEL = 8;
  localparam int BIT_CLIPPED = 7;
  localparam int BIT_CONV_DONE = 6;
  localparam int BIT_SEQ_DONE = 5;
  localparam int BIT_SEQ_STARTED = 4;
  localparam int BIT_CMD_BEGIN = 3;
  localparam int BIT_CMD_ABORTED = 2;
  localparam int BIT_READY = 0;
  localparam logic [FLAG_W-1:0] FLAG_MASK = 11'h7FD;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 11'h000;

  // Indirect access field widths and reset values
  localparam int BYTE_W = 8;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] READ_RESET = 8'h00;
  localparam int STATUS_ERR_BIT = 0;

  // Cycles the core may take to acknowledge before the access errors
  localparam int ACK_TIMEOUT_NS = 64;
  localparam int CLOCK_NS = 4;
  localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_NS / CLOCK_NS;
  localparam int TMO_W = 5;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // Request toward the converter core configuration space
  typedef struct packed {
    logic req;
    logic write;
    logic [BYTE_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } cfg_req_t;

  // Answer from the converter core configuration space
  typedef struct packed {
    logic ack;
    logic [BYTE_W-1:0] rdata;
  } cfg_rsp_t;

endpackage

// [core/cfg_access.sv]
/*
  Indirect configuration transaction engine: issues one read or write
  to the converter core, waits for acknowledge with a timeout, and
  reports read byte and error.
  Assumes the core answers on the same clock and holds ack one cycle.
*/
module cfg_access (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire evreg_pkg::cfg_rsp_t i_rsp,
  output evreg_pkg::cfg_req_t o_req,
  output logic o_done,
  output logic o_error,
  output logic [7:0] o_rdata
);

  typedef enum logic [0:0] {IDLE, WAIT} state_t;
  state_t state_reg;
  logic [evreg_pkg::TMO_W-1:0] tmo_reg;

  ////////////////////////////////////////////////////////////////////
  // Sequence: a start while busy restarts the transaction
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= IDLE;
      tmo_reg <= '0;
      o_req <= '0;
      o_done <= 1'b0;
      o_error <= 1'b0;
      o_rdata <= evreg_pkg::READ_RESET;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        state_reg <= WAIT;
        tmo_reg <= '0;
        o_req <= '{req: 1'b1, write: i_write, addr: i_addr,
                   wdata: i_wdata};
      end else begin
        unique case (state_reg)
          IDLE: begin
            o_req.req <= 1'b0;
          end
          WAIT: begin
            if (i_rsp.ack) begin
              state_reg <= IDLE;
              o_req.req <= 1'b0;
              o_done <= 1'b1;
              o_error <= 1'b0;
              if (!o_req.write) begin
                o_rdata <= i_rsp.rdata;
              end
            end else if (tmo_reg ==
                         evreg_pkg::TMO_W'(evreg_pkg::ACK_TIMEOUT_CYC)) begin
              // No acknowledge in time counts as a refused access
              state_reg <= IDLE;
              o_req.req <= 1'b0;
              o_done <= 1'b1;
              o_error <= 1'b1;
            end else begin
              tmo_reg <= tmo_reg + 1'b1;
            end
          end
        endcase
      end
    end
  end

endmodule

// [core/event_reg_bank.sv]
/*
  Converter event flags, interrupt enables and indirect configuration
  register window.
  Assumes event inputs are one-cycle pulses from logic on i_clock and
  the register master follows the single-cycle strobe protocol.
*/
// The strobed register port was left to the implementer.
module event_reg_bank (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [10:0] i_events,
  input wire evreg_pkg::cfg_rsp_t i_cfg_rsp,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output evreg_pkg::cfg_req_t o_cfg_req
);

  logic [evreg_pkg::FLAG_W-1:0] flags_reg;
  logic [evreg_pkg::FLAG_W-1:0] enables_reg;
  logic [7:0] base_reg;
  logic [7:0] address_reg;
  logic [7:0] write_byte_reg;
  logic status_reg;
  logic start;
  logic start_write;
  logic [7:0] eff_addr;
  logic eng_done;
  logic eng_error;
  logic [7:0] eng_rdata;
  evreg_pkg::reg_req_t req;

  // Widen a byte to a bus word
  function automatic logic [31:0] word8(input logic [7:0] b);
    word8 = {24'h000000, b};
  endfunction

  // Bus word to flag field
  function automatic logic [evreg_pkg::FLAG_W-1:0] flag_field(
      input logic [31:0] w);
    flag_field = w[evreg_pkg::FLAG_W-1:0] & evreg_pkg::FLAG_MASK;
  endfunction

  assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  ////////////////////////////////////////////////////////////////////
  // Flags: an event in the clearing cycle still sets its flag
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flags_reg <= evreg_pkg::FLAG_RESET;
    end else begin
      logic [evreg_pkg::FLAG_W-1:0] clr;
      clr = '0;
      if (req.wr && req.addr == evreg_pkg::OFF_EVENT_FLAGS) begin
        clr = flag_field(req.wdata);
      end
      // Bit 1 is reserved and never sets
      flags_reg <= (flags_reg & ~clr)
                   | (i_events & evreg_pkg::FLAG_MASK);
    end
  end

  // Enables: plain read/write mask of the flag layout
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      enables_reg <= evreg_pkg::FLAG_RESET;
    end else if (req.wr && req.addr == evreg_pkg::OFF_EVENT_ENABLES) begin
      enables_reg <= flag_field(req.wdata);
    end
  end

  // Interrupt level, registered for a clean output
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(flags_reg & enables_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Indirect window registers
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      base_reg <= evreg_pkg::BYTE_RESET;
      address_reg <= evreg_pkg::BYTE_RESET;
      write_byte_reg <= evreg_pkg::BYTE_RESET;
    end else if (req.wr) begin
      if (req.addr == evreg_pkg::OFF_BASE_OFFSET) begin
        base_reg <= req.wdata[7:0];
      end
      if (req.addr == evreg_pkg::OFF_IND_ADDRESS) begin
        address_reg <= req.wdata[7:0];
      end
      if (req.addr == evreg_pkg::OFF_IND_WRITE) begin
        write_byte_reg <= req.wdata[7:0];
      end
    end
  end

  // A write to address or read byte starts a read, to write byte a write
  assign start_write = req.wr && req.addr == evreg_pkg::OFF_IND_WRITE;
  assign start = start_write || (req.wr &&
                 (req.addr == evreg_pkg::OFF_IND_ADDRESS ||
                  req.addr == evreg_pkg::OFF_IND_READ));

  // Target address uses the new address byte when it is being written
  assign eff_addr = 8'((req.addr == evreg_pkg::OFF_IND_ADDRESS ?
                        req.wdata[7:0] : address_reg) + base_reg);

  cfg_access u_cfg_access (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_start(start),
    .i_write(start_write),
    .i_addr(eff_addr),
    .i_wdata(start_write ? req.wdata[7:0] : write_byte_reg),
    .i_rsp(i_cfg_rsp),
    .o_req(o_cfg_req),
    .o_done(eng_done),
    .o_error(eng_error),
    .o_rdata(eng_rdata)
  );

  // Error status: cleared at a start, set from the engine outcome
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_reg <= 1'b0;
    end else if (start) begin
      status_reg <= 1'b0;
    end else if (eng_done) begin
      status_reg <= eng_error;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data: one cycle after the strobe, zero otherwise and unmapped
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else if (req.rd) begin
      unique case (req.addr)
        evreg_pkg::OFF_EVENT_FLAGS: o_rdata <= {21'h000000, flags_reg};
        evreg_pkg::OFF_EVENT_ENABLES: o_rdata <= {21'h000000, enables_reg};
        evreg_pkg::OFF_BASE_OFFSET: o_rdata <= word8(base_reg);
        evreg_pkg::OFF_IND_ADDRESS: o_rdata <= word8(address_reg);
        evreg_pkg::OFF_IND_WRITE: o_rdata <= word8(write_byte_reg);
        evreg_pkg::OFF_IND_READ: o_rdata <= word8(eng_rdata);
        evreg_pkg::OFF_IND_STATUS: o_rdata <= {31'h00000000, status_reg};
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

endmodule

// [tb/core_cfg_model.sv]
/*
  Model of the converter core configuration space.
  Assumes one clock; acks after i_delay cycles unless i_mute is high.
*/
module core_cfg_model (
  input wire logic i_clock,
  input wire logic [7:0] i_delay,
  input wire logic i_mute,
  input wire evreg_pkg::cfg_req_t i_req,
  output evreg_pkg::cfg_rsp_t o_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] cnt = 8'h00;
  initial o_rsp = '0;
  // One-cycle ack; FF parks the count so one request gets one ack
  always @(posedge i_clock) begin
    o_rsp.ack <= 1'b0;
    o_rsp.rdata <= ~o_rsp.rdata; // Byte is inverted every cycle outside the ack
    if (!i_req.req) cnt <= 8'h00;
    else if (cnt == i_delay && !i_mute) begin
      o_rsp.ack <= 1'b1;
      o_rsp.rdata <= mem[i_req.addr];
      if (i_req.write) mem[i_req.addr] <= i_req.wdata;
      cnt <= 8'hFF;
    end else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
  end
endmodule

// [tb/event_reg_bank_monitor.sv]
/*
  Port checker for the event register bank.
  Assumes it is bound to every event_reg_bank instance.
*/
module event_reg_bank_monitor (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [10:0] i_events,
  input wire evreg_pkg::cfg_rsp_t i_cfg_rsp,
  input wire logic [31:0] o_rdata,
  input wire logic o_irq,
  input wire evreg_pkg::cfg_req_t o_cfg_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////////////
  property p_idle; !i_rd |=> o_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data without read");
  property p_flg; i_rd && i_addr == 8'h54 |=> !o_rdata[1]; endproperty
  a_flg: assert property (p_flg) else $error("flag bit 1 set");
  property p_bas; i_rd && i_addr == 8'h60 |=> !(|o_rdata[31:8]);
  endproperty
  a_bas: assert property (p_bas) else $error("offset high bits");
  property p_sts; i_rd && i_addr == 8'h70 |=> !(|o_rdata[31:1]);
  endproperty
  a_sts: assert property (p_sts) else $error("status high bits");
  property p_adr; i_wr && i_addr == 8'h64 |=> o_cfg_req.req &&
    !o_cfg_req.write; endproperty
  a_adr: assert property (p_adr) else $error("no read start");
  property p_wrs; i_wr && i_addr == 8'h68 |=> o_cfg_req.write &&
    o_cfg_req.req && o_cfg_req.wdata == $past(i_wdata[7:0]); endproperty
  a_wrs: assert property (p_wrs) else $error("bad write start");
  property p_ack; o_cfg_req.req && i_cfg_rsp.ack && !i_wr |=>
    !o_cfg_req.req; endproperty
  a_ack: assert property (p_ack) else $error("held after ack");
  property p_tmo; o_cfg_req.req |-> ##[0:20] (!o_cfg_req.req || i_wr);
  endproperty
  a_tmo: assert property (p_tmo) else $error("no timeout");
  property p_irq; i_wr && i_addr == 8'h54 && i_wdata[10:0] == 11'h7FF
    && i_events == 11'h000 ##1 i_events == 11'h000 |=> !o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq after clear");
endmodule
bind event_reg_bank event_reg_bank_monitor mon_u (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_events(i_events), .i_cfg_rsp(i_cfg_rsp),
  .o_rdata(o_rdata), .o_irq(o_irq), .o_cfg_req(o_cfg_req));

// [tb/event_reg_bank_tb.sv]
/*
  Self-checking bench for the event register bank.
  Assumes the core model answers the indirect path.
*/
module event_reg_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic rd_d = 1'b0, i_mute = 1'b0, o_irq;
  logic [7:0] i_addr = 8'h00, i_delay = 8'h00, a, d, base;
  logic [31:0] i_wdata = 32'h0, o_rdata, w;
  logic [10:0] i_events = 11'h000, fl;
  evreg_pkg::cfg_req_t cfg_req;
  evreg_pkg::cfg_rsp_t cfg_rsp;
  logic [31:0] exp_q [$];
  int errors = 0;
  int checks_done = 0;
  // Every mapped register, then one unmapped place
  logic [7:0] offs [8] = '{8'h54, 8'h50, 8'h60, 8'h64, 8'h68, 8'h6C,
    8'h70, 8'h44};
  event_reg_bank dut_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_events(i_events), .i_cfg_rsp(cfg_rsp), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_cfg_req(cfg_req));
  core_cfg_model core_u (.i_clock(i_clock), .i_delay(i_delay),
    .i_mute(i_mute), .i_req(cfg_req), .o_rsp(cfg_rsp));
  ////////////////////////////////////////////////////////////////////
  always #2 i_clock = ~i_clock;
  task final_report;
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    checks_done++;
    if (!ok) begin
      errors++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge i_clock) {i_wr, i_addr, i_wdata} <= {1'b1, ad, v};
    @(posedge i_clock) i_wr <= 1'b0;
  endtask
  // Reads leave their expectation in the queue
  task rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge i_clock) {i_rd, i_addr} <= {1'b1, ad};
    exp_q.push_back(e);
    @(posedge i_clock) i_rd <= 1'b0;
  endtask
  // Bounded wait for the core request to finish, checking its address
  task waitreq(input logic [7:0] ea);
    int n;
    @(negedge i_clock);
    chk(cfg_req.req === 1'b1 && cfg_req.addr === ea, "req");
    for (n = 0; n < 40 && cfg_req.req === 1'b1; n++) @(negedge i_clock);
    if (n == 40) begin
      chk(1'b0, "hang");
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  always @(posedge i_clock) rd_d <= i_rd;
  // Answer is settled mid-cycle after the strobe
  always @(negedge i_clock) if (rd_d) chk(o_rdata === exp_q.pop_front(),
    "read data");
  initial begin
    void'($urandom(32'h6C51));
    repeat (6) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    // Reset values, then an unmapped place
    foreach (offs[k]) rd(offs[k], 32'h0);
    fl = 11'h000;
    // Every event source in turn; bit 1 never latches
    for (int i = 0; i < 11; i++) begin
      @(posedge i_clock) i_events <= 11'h001 << i;
      @(posedge i_clock) i_events <= 11'h000;
      fl |= (11'h001 << i) & 11'h7FD;
      rd(8'h54, {21'h0, fl});
    end
    @(negedge i_clock);
    chk(o_irq === 1'b0, "irq masked");
    // Upper enable bits are not stored
    wr(8'h50, 32'hFFFFF008);
    rd(8'h50, 32'h8);
    repeat (2) @(negedge i_clock);
    chk(o_irq === 1'b1, "irq enabled");
    wr(8'h54, 32'h8);
    repeat (2) @(negedge i_clock);
    chk(o_irq === 1'b0, "irq cleared");
    rd(8'h54, {21'h0, fl & 11'h7F7});
    // Event and clear in one cycle: the event wins
    @(posedge i_clock) begin
      i_events <= 11'h020;
      {i_wr, i_addr, i_wdata} <= {1'b1, 8'h54, 32'hFFFFFFFF};
    end
    @(posedge i_clock) begin
      i_events <= 11'h000;
      i_wr <= 1'b0;
    end
    rd(8'h54, 32'h20);
    wr(8'h54, 32'hFFFFFFFF);
    rd(8'h54, 32'h0);
    w = $urandom;
    base = w[7:0];
    wr(8'h60, w);
    rd(8'h60, {24'h0, base});
    // Write then read back through the core, with growing delay
    for (int k = 0; k < 3; k++) begin
      a = 8'($urandom);
      d = 8'($urandom);
      i_delay <= 8'(k * 3);
      wr(8'h64, {24'h0, a});
      waitreq(a + base);
      wr(8'h68, {24'h0, d});
      waitreq(a + base);
      wr(8'h6C, 32'h0);
      waitreq(a + base);
      rd(8'h6C, {24'h0, d});
      rd(8'h70, 32'h0);
      rd(8'h64, {24'h0, a});
      rd(8'h68, {24'h0, d});
    end
    // Silent core errors; the next access clears the error
    i_mute <= 1'b1;
    wr(8'h64, {24'h0, a});
    waitreq(a + base);
    rd(8'h70, 32'h1);
    i_mute <= 1'b0;
    wr(8'h6C, 32'h0);
    waitreq(a + base);
    rd(8'h70, 32'h0);
    rd(8'h6C, {24'h0, d});
    // Mid-run reset returns the window and the enables to zero
    @(posedge i_clock) i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    rd(8'h50, 32'h0);
    rd(8'h64, 32'h0);
    rd(8'h68, 32'h0);
    rd(8'h6C, 32'h0);
    repeat (2) @(posedge i_clock);
    final_report();
  end
endmodule
